// *** common/pmc_pkg.sv ***
package pmc_pkg;

  // ******************************
  // Register offsets
  // ******************************
  localparam logic [11:0] PMC_OFF_PM  = 12'h0C4;
  localparam logic [11:0] PMC_OFF_CAP = 12'h0D0;
  localparam logic [11:0] PMC_OFF_ALO = 12'h0D4;
  localparam logic [11:0] PMC_OFF_AHI = 12'h0D8;
  localparam logic [11:0] PMC_OFF_DAT = 12'h0DC;

  // ******************************
  // Field positions
  // ******************************
  localparam int PMC_PS_LSB  = 0;
  localparam int PMC_CTX_BIT = 3;
  localparam int PMC_PEN_BIT = 8;
  localparam int PMC_PST_BIT = 15;
  localparam int PMC_ID_LSB  = 0;
  localparam int PMC_NP_LSB  = 8;
  localparam int PMC_EN_BIT  = 16;
  localparam int PMC_MMC_LSB = 17;
  localparam int PMC_MME_LSB = 20;
  localparam int PMC_A64_BIT = 23;
  localparam int PMC_ALO_LSB = 2;

  // ******************************
  // Fixed and reset values
  // ******************************
  localparam logic [7:0] PMC_CAP_ID  = 8'h05;
  localparam logic [7:0] PMC_NP_RST  = 8'h00;
  localparam logic [2:0] PMC_MMC_VAL = 3'h0;
  localparam logic [2:0] PMC_MME_VAL = 3'h0;
  localparam logic       PMC_A64_VAL = 1'h1;
  localparam logic       PMC_CTX_RST = 1'h1;
  localparam logic       PMC_PEN_RST = 1'h0;
  localparam logic       PMC_PST_RST = 1'h0;
  localparam logic       PMC_EN_RST  = 1'h0;

  // ******************************
  // Types
  // ******************************
  typedef enum logic [1:0] {
    PMC_PS_D0  = 2'h0,
    PMC_PS_D1  = 2'h1,
    PMC_PS_D2  = 2'h2,
    PMC_PS_D3H = 2'h3
  } pmc_power_state_sel_e;

  typedef enum logic {
    PMC_MS_IDLE = 1'h0,
    PMC_MS_SEND = 1'h1
  } pmc_msi_st_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pmc_cfg_req_s;

  typedef struct packed {
    logic [63:0] addr;
    logic        wide;
    logic [15:0] data;
  } pmc_msi_wr_s;

  typedef struct packed {
    pmc_power_state_sel_e ps;
    logic        ctx;
    logic [7:0]  np;
    logic        en;
    logic [29:0] alo;
    logic [31:0] ahi;
    logic [15:0] dat;
    pmc_msi_st_e ms;
    logic        pend;
    pmc_msi_wr_s msi;
    logic [31:0] rdata;
    logic        rvalid;
    logic        pmsg;
    logic        up;
    logic        strap;
  } pmc_core_s;

  typedef struct packed {
    logic en;
    logic st;
  } pmc_sticky_s;

  localparam pmc_core_s PMC_CORE_RST = '{
    ps: PMC_PS_D0, ctx: PMC_CTX_RST, np: PMC_NP_RST, en: PMC_EN_RST,
    alo: 30'h0, ahi: 32'h0, dat: 16'h0, ms: PMC_MS_IDLE, pend: 1'h0,
    msi: '{addr: 64'h0, wide: 1'h0, data: 16'h0},
    rdata: 32'h0, rvalid: 1'h0, pmsg: 1'h0, up: 1'h0, strap: 1'h0
  };

  localparam pmc_sticky_s PMC_STICKY_RST = '{
    en: PMC_PEN_RST, st: PMC_PST_RST
  };

endpackage

// *** core/pmc_pme_sticky.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_pme_sticky (
  // Clock and full reset
  input  wire logic clk,
  input  wire logic rst,
  // Register write
  input  wire logic wr_en,
  input  wire logic en_wdata,
  input  wire logic st_w1c,
  // Port event
  input  wire logic evt,
  input  wire logic no_origin,
  // Sticky state
  output logic      en,
  output logic      st
);

  pmc_pkg::pmc_sticky_s st_ff;
  pmc_pkg::pmc_sticky_s nxt_st;

  // ******************************
  // Sticky enable and status
  // ******************************
  // Only the full reset reaches here; hot reset is kept out on purpose
  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      nxt_st.en = en_wdata;
      if (st_w1c) begin
        nxt_st.st = 1'h0;
      end
    end
    // Set beats clear; forwarded messages never arrive on evt
    if (evt && !no_origin) begin
      nxt_st.st = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= pmc_pkg::PMC_STICKY_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign en = st_ff.en;
  assign st = st_ff.st;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  status_set_a: assert property (
    evt && !no_origin |=> st)
    else $error("status missed a port event");
  upstream_quiet_a: assert property (
    no_origin && !st && !(evt && !no_origin) |=> !st)
    else $error("status set without own event");
  enable_write_a: assert property (
    wr_en |=> en == $past(en_wdata))
    else $error("enable did not take write");

endmodule // pmc_pme_sticky

`default_nettype wire

// *** core/pmc_port_cfg.sv ***
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Two-bit power state reads, selects D0/D3hot
// - Codes one and two are reserved
// - Context-kept flag resets to one
// - Event enable gates event messages, sticky
// - Hot reset leaves event enable alone
// - Own event sets status; write one clears
// - Forwarded events leave status untouched
// - Upstream port never sets status
// - Data select, scale, byte read zero
// - Bus state bits read zero
// - Capability identifier reads fixed five
// - Next pointer zero, writable only unlocked
// - Interrupts issued only while enable set
// - Single message: capable zero, enabled fixed
// - Wide-address capable bit reads one
// - Wide address only when upper nonzero
// - Message carries programmed 16-bit payload
module pmc_port_cfg (
  // Clock and resets
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  hot_rst,
  // Configuration access
  input  wire pmc_pkg::pmc_cfg_req_s cfg_req,
  input  wire logic                  cfg_unlock,
  output logic [31:0]                cfg_rdata,
  output logic                       cfg_rvalid,
  // Port role
  input  wire logic                  upstream_strap,
  // Power management
  input  wire logic                  pme_gen,
  output logic                       pm_event_msg,
  output logic [1:0]                 power_state,
  // Interrupt messages
  input  wire logic                  msi_req,
  input  wire logic                  msi_wr_ready,
  output logic                       msi_wr_valid,
  output pmc_pkg::pmc_msi_wr_s       msi_wr
);

  // ******************************
  // State and decode
  // ******************************
  pmc_pkg::pmc_core_s st_ff;
  pmc_pkg::pmc_core_s nxt_st;

  logic        wr_pm;
  logic        wr_cap;
  logic        wr_alo;
  logic        wr_ahi;
  logic        wr_dat;
  logic        ps_legal;
  logic        up_eff;
  logic        ctx_loss;
  logic        pen;
  logic        pst;
  logic [31:0] pm_word;
  logic [31:0] cap_word;
  logic [31:0] rd_word;
  logic [1:0]  ps_wr;

  assign wr_pm  = cfg_req.wr && (cfg_req.addr == pmc_pkg::PMC_OFF_PM);
  assign wr_cap = cfg_req.wr && (cfg_req.addr == pmc_pkg::PMC_OFF_CAP);
  assign wr_alo = cfg_req.wr && (cfg_req.addr == pmc_pkg::PMC_OFF_ALO);
  assign wr_ahi = cfg_req.wr && (cfg_req.addr == pmc_pkg::PMC_OFF_AHI);
  assign wr_dat = cfg_req.wr && (cfg_req.addr == pmc_pkg::PMC_OFF_DAT);

  assign ps_wr = cfg_req.wdata[pmc_pkg::PMC_PS_LSB +: 2];

  // Only full on and D3hot are accepted
  assign ps_legal = (ps_wr == pmc_pkg::PMC_PS_D0) ||
                    (ps_wr == pmc_pkg::PMC_PS_D3H);

  // Until the strap is caught, assume upstream so nothing is raised
  assign up_eff = st_ff.up || !st_ff.strap;

  // D3hot to D0 without context kept wipes the interrupt setup
  assign ctx_loss = wr_pm && ps_legal && !st_ff.ctx &&
                    (st_ff.ps == pmc_pkg::PMC_PS_D3H) &&
                    (ps_wr == pmc_pkg::PMC_PS_D0);

  // ******************************
  // Sticky event bits
  // ******************************
  pmc_pme_sticky u_sticky (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (wr_pm),
    .en_wdata  (cfg_req.wdata[pmc_pkg::PMC_PEN_BIT]),
    .st_w1c    (cfg_req.wdata[pmc_pkg::PMC_PST_BIT]),
    .evt       (pme_gen),
    .no_origin (up_eff),
    .en        (pen),
    .st        (pst)
  );

  // ******************************
  // Read words
  // ******************************
  always_comb begin
    pm_word = 32'h0;
    pm_word[pmc_pkg::PMC_PS_LSB +: 2] = st_ff.ps;
    pm_word[pmc_pkg::PMC_CTX_BIT] = st_ff.ctx;
    pm_word[pmc_pkg::PMC_PEN_BIT] = pen;
    pm_word[pmc_pkg::PMC_PST_BIT] = pst;
  end

  always_comb begin
    cap_word = 32'h0;
    cap_word[pmc_pkg::PMC_ID_LSB +: 8] = pmc_pkg::PMC_CAP_ID;
    cap_word[pmc_pkg::PMC_NP_LSB +: 8] = st_ff.np;
    cap_word[pmc_pkg::PMC_EN_BIT] = st_ff.en;
    cap_word[pmc_pkg::PMC_MMC_LSB +: 3] = pmc_pkg::PMC_MMC_VAL;
    cap_word[pmc_pkg::PMC_MME_LSB +: 3] = pmc_pkg::PMC_MME_VAL;
    cap_word[pmc_pkg::PMC_A64_BIT] = pmc_pkg::PMC_A64_VAL;
  end

  always_comb begin
    case (cfg_req.addr)
      pmc_pkg::PMC_OFF_PM: begin
        rd_word = pm_word;
      end
      pmc_pkg::PMC_OFF_CAP: begin
        rd_word = cap_word;
      end
      pmc_pkg::PMC_OFF_ALO: begin
        rd_word = {st_ff.alo, 2'h0};
      end
      pmc_pkg::PMC_OFF_AHI: begin
        rd_word = st_ff.ahi;
      end
      pmc_pkg::PMC_OFF_DAT: begin
        rd_word = {16'h0, st_ff.dat};
      end
      default: begin
        rd_word = 32'h0;
      end
    endcase
  end

  // ******************************
  // Next state
  // ******************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'h0;
    nxt_st.pmsg = 1'h0;

    // Port role is caught once after full reset release
    if (!st_ff.strap) begin
      nxt_st.up = upstream_strap;
      nxt_st.strap = 1'h1;
    end

    // Power management control
    if (wr_pm) begin
      if (ps_legal) begin
        nxt_st.ps = pmc_pkg::pmc_power_state_sel_e'(ps_wr);
      end
      if (cfg_unlock) begin
        nxt_st.ctx = cfg_req.wdata[pmc_pkg::PMC_CTX_BIT];
      end
    end

    // Capability header; the message-count field ignores writes
    if (wr_cap) begin
      nxt_st.en = cfg_req.wdata[pmc_pkg::PMC_EN_BIT];
      if (cfg_unlock) begin
        nxt_st.np = cfg_req.wdata[pmc_pkg::PMC_NP_LSB +: 8];
      end
    end
    if (wr_alo) begin
      nxt_st.alo = cfg_req.wdata[31:pmc_pkg::PMC_ALO_LSB];
    end
    if (wr_ahi) begin
      nxt_st.ahi = cfg_req.wdata;
    end
    if (wr_dat) begin
      nxt_st.dat = cfg_req.wdata[15:0];
    end

    // Own events become messages only when enabled
    nxt_st.pmsg = pme_gen && pen && !up_eff;

    // Interrupt message sequencer
    case (st_ff.ms)
      pmc_pkg::PMC_MS_IDLE: begin
        if ((msi_req || st_ff.pend) && st_ff.en) begin
          nxt_st.ms = pmc_pkg::PMC_MS_SEND;
          nxt_st.pend = 1'h0;
          nxt_st.msi.data = st_ff.dat;
          if (st_ff.ahi != 32'h0) begin
            nxt_st.msi.wide = 1'h1;
            nxt_st.msi.addr = {st_ff.ahi, st_ff.alo, 2'h0};
          end else begin
            nxt_st.msi.wide = 1'h0;
            nxt_st.msi.addr = {32'h0, st_ff.alo, 2'h0};
          end
        end
      end
      pmc_pkg::PMC_MS_SEND: begin
        // One request may wait while a message is out
        if (msi_req) begin
          nxt_st.pend = 1'h1;
        end
        if (msi_wr_ready) begin
          nxt_st.ms = pmc_pkg::PMC_MS_IDLE;
        end
      end
      default: begin
        nxt_st.ms = pmc_pkg::PMC_MS_IDLE;
      end
    endcase
    // A disabled port forgets a waiting request
    if (!st_ff.en) begin
      nxt_st.pend = 1'h0;
    end

    // Context lost on return to full power
    if (ctx_loss) begin
      nxt_st.en = pmc_pkg::PMC_EN_RST;
      nxt_st.alo = 30'h0;
      nxt_st.ahi = 32'h0;
      nxt_st.dat = 16'h0;
      nxt_st.pend = 1'h0;
    end

    // Reads return the value before a same-cycle write
    if (cfg_req.rd) begin
      nxt_st.rvalid = 1'h1;
      nxt_st.rdata = rd_word;
    end
  end

  // ******************************
  // State register
  // ******************************
  // Hot reset clears all but the caught port role; the sticky
  // event bits live in the submodule, out of its reach
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= pmc_pkg::PMC_CORE_RST;
    end else if (hot_rst) begin
      st_ff <= pmc_pkg::PMC_CORE_RST;
      st_ff.up <= st_ff.up;
      st_ff.strap <= st_ff.strap;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  assign cfg_rdata    = st_ff.rdata;
  assign cfg_rvalid   = st_ff.rvalid;
  assign pm_event_msg = st_ff.pmsg;
  assign power_state  = st_ff.ps;
  assign msi_wr_valid = (st_ff.ms == pmc_pkg::PMC_MS_SEND);
  assign msi_wr       = st_ff.msi;

  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || hot_rst);

  sequence s_rd_pm;
    cfg_req.rd && cfg_req.addr == pmc_pkg::PMC_OFF_PM;
  endsequence

  sequence s_rd_cap;
    cfg_req.rd && cfg_req.addr == pmc_pkg::PMC_OFF_CAP;
  endsequence

  sequence s_msi_launch;
    !msi_wr_valid ##1 msi_wr_valid;
  endsequence

  ps_legal_a: assert property (
    st_ff.ps == pmc_pkg::PMC_PS_D0 || st_ff.ps == pmc_pkg::PMC_PS_D3H)
    else $error("power state holds reserved code");
  ps_write_a: assert property (
    wr_pm && ps_legal |=> power_state == $past(ps_wr))
    else $error("legal power state not taken");
  ps_reserved_a: assert property (
    wr_pm && !ps_legal |=> $stable(power_state))
    else $error("reserved power state changed field");
  pm_zero_a: assert property (
    s_rd_pm |=> cfg_rvalid && cfg_rdata[31:16] == 16'h0 &&
      cfg_rdata[14:9] == 6'h0 && cfg_rdata[7:4] == 4'h0 &&
      !cfg_rdata[2])
    else $error("unimplemented power bits not zero");
  cap_fixed_a: assert property (
    s_rd_cap |=> cfg_rvalid && cfg_rdata[7:0] == 8'h05 &&
      cfg_rdata[23:17] == 7'h40 && cfg_rdata[31:24] == 8'h00)
    else $error("capability fixed fields wrong");
  np_lock_a: assert property (
    wr_cap && !cfg_unlock |=> $stable(st_ff.np))
    else $error("next pointer written while locked");
  msi_enable_a: assert property (
    s_msi_launch |-> $past(st_ff.en))
    else $error("message issued while disabled");
  msi_wide_a: assert property (
    s_msi_launch |-> msi_wr.wide == ($past(st_ff.ahi) != 32'h0) &&
      (msi_wr.wide || msi_wr.addr[63:32] == 32'h0))
    else $error("message address width wrong");
  msi_data_a: assert property (
    s_msi_launch |-> msi_wr.data == $past(st_ff.dat))
    else $error("message payload wrong");
  pm_msg_a: assert property (
    pm_event_msg |-> $past(pen) && $past(pme_gen))
    else $error("event message without enable");
  hot_keep_a: assert property (
    @(posedge clk) disable iff (rst)
    hot_rst |=> pen == $past(pen) && pst == $past(pst))
    else $error("hot reset touched sticky bits");

endmodule // pmc_port_cfg

`default_nettype wire

// *** test/pmc_msi_sink.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_msi_sink (
  // Clock
  input  wire logic                 clk,
  // Pace control
  input  wire logic                 slow,
  // Message port
  input  wire logic                 msi_wr_valid,
  input  wire pmc_pkg::pmc_msi_wr_s msi_wr,
  output logic                      msi_wr_ready,
  // Capture
  output int                        msg_cnt,
  output pmc_pkg::pmc_msi_wr_s      last_msg
);
  logic [1:0] gap_ff;

  initial begin
    msi_wr_ready = 1'b0;
    msg_cnt = 0;
    last_msg = '0;
    gap_ff = 2'h0;
  end

  // Slow mode takes one cycle in four, like a backed-up upstream path
  always @(posedge clk) begin
    gap_ff <= gap_ff + 2'h1;
    msi_wr_ready <= !slow || (gap_ff == 2'h3);
    if (msi_wr_valid && msi_wr_ready) begin
      msg_cnt <= msg_cnt + 1;
      last_msg <= msi_wr;
    end
  end
endmodule // pmc_msi_sink

`default_nettype wire

// *** test/pmc_port_cfg_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmc_port_cfg_tb;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  hot_rst = 1'b0;
  logic                  cfg_unlock = 1'b0;
  logic                  upstream_strap = 1'b0;
  logic                  pme_gen = 1'b0;
  logic                  msi_req = 1'b0;
  logic                  slow = 1'b0;
  pmc_pkg::pmc_cfg_req_s req = '0;
  logic [31:0]           cfg_rdata;
  logic                  cfg_rvalid;
  logic                  pm_event_msg;
  logic [1:0]            power_state;
  logic                  msi_wr_valid;
  logic                  msi_wr_ready;
  pmc_pkg::pmc_msi_wr_s  msi_wr;
  pmc_pkg::pmc_msi_wr_s  last_msg;
  int                    msg_cnt;
  int                    err_total = 0;
  int                    comparisons = 0;
  int                    seed = 86800;
  int                    n;
  logic [31:0]           alo;
  logic [31:0]           ahi;
  logic [15:0]           dat;

  always #25 clk = ~clk;

  pmc_port_cfg u_dut (
    .clk(clk), .rst(rst), .hot_rst(hot_rst), .cfg_req(req),
    .cfg_unlock(cfg_unlock), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .upstream_strap(upstream_strap), .pme_gen(pme_gen),
    .pm_event_msg(pm_event_msg), .power_state(power_state),
    .msi_req(msi_req), .msi_wr_ready(msi_wr_ready),
    .msi_wr_valid(msi_wr_valid), .msi_wr(msi_wr)
  );

  pmc_msi_sink u_sink (
    .clk(clk), .slow(slow), .msi_wr_valid(msi_wr_valid), .msi_wr(msi_wr),
    .msi_wr_ready(msi_wr_ready), .msg_cnt(msg_cnt), .last_msg(last_msg)
  );

  // ******************************
  // Helpers
  // ******************************
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cfg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data answers exactly one cycle after the request
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    check("cfg_rvalid", cfg_rvalid, 1'b1);
    check("cfg_rdata", cfg_rdata, exp);
  endtask

  task automatic pulse(input bit is_msi);
    @(posedge clk);
    if (is_msi) msi_req <= 1'b1;
    else pme_gen <= 1'b1;
    @(posedge clk);
    msi_req <= 1'b0;
    pme_gen <= 1'b0;
    #1;
  endtask

  task automatic do_reset(input logic strap);
    @(posedge clk);
    upstream_strap <= strap;
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask

  function automatic logic [63:0] exp_addr(input logic [31:0] lo,
                                            input logic [31:0] hi);
    return {hi, lo[31:2], 2'h0};
  endfunction

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_0008);
    rd_chk(pmc_pkg::PMC_OFF_CAP, 32'h0080_0005);
    rd_chk(12'h0C8, 32'h0000_0000);
    // Locked context flag and read-only fields must hold
    cfg_wr(pmc_pkg::PMC_OFF_PM, 32'hFFFF_7FFF);
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_010B);
    check("power_state", power_state, 2'h3);
    for (int c = 1; c < 3; c++) begin
      cfg_wr(pmc_pkg::PMC_OFF_PM, 32'h0000_0100 | c);
      rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_010B);
      check("power_state", power_state, 2'h3);
    end
    pulse(1'b0);
    check("pm_event_msg", pm_event_msg, 1'b1);
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_810B);
    cfg_wr(pmc_pkg::PMC_OFF_PM, 32'h0000_8100);
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_0108);
    cfg_wr(pmc_pkg::PMC_OFF_PM, 32'h0000_0000);
    pulse(1'b0);
    check("pm_event_msg", pm_event_msg, 1'b0);
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_8008);
    cfg_wr(pmc_pkg::PMC_OFF_PM, 32'h0000_0103);
    @(posedge clk);
    hot_rst <= 1'b1;
    repeat (2) @(posedge clk);
    hot_rst <= 1'b0;
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_8108);
    // Next pointer only moves while unlocked
    cfg_wr(pmc_pkg::PMC_OFF_CAP, 32'hFF7E_AB00);
    rd_chk(pmc_pkg::PMC_OFF_CAP, 32'h0080_0005);
    @(posedge clk);
    cfg_unlock <= 1'b1;
    cfg_wr(pmc_pkg::PMC_OFF_CAP, 32'hFFFF_FFFF);
    cfg_unlock <= 1'b0;
    rd_chk(pmc_pkg::PMC_OFF_CAP, 32'h0081_FF05);
    for (int k = 0; k < 4; k++) begin
      alo = $random(seed);
      ahi = k[0] ? $random(seed) : 32'h0;
      dat = $random(seed);
      slow <= k[1];
      cfg_wr(pmc_pkg::PMC_OFF_ALO, alo);
      cfg_wr(pmc_pkg::PMC_OFF_AHI, ahi);
      cfg_wr(pmc_pkg::PMC_OFF_DAT, {16'hFFFF, dat});
      rd_chk(pmc_pkg::PMC_OFF_ALO, {alo[31:2], 2'h0});
      n = msg_cnt;
      pulse(1'b1);
      for (int i = 0; i < 20 && msg_cnt == n; i++) @(posedge clk);
      // Timeout counts as a mismatch; the run goes on to the report
      if (msg_cnt == n) begin
        err_total++;
        $display("[FAIL] msi_wr expected message seen none");
      end else begin
        check("msi addr", last_msg.addr, exp_addr(alo, ahi));
        check("msi wide", last_msg.wide, ahi != 32'h0);
        check("msi data", last_msg.data, dat);
      end
    end
    cfg_wr(pmc_pkg::PMC_OFF_CAP, 32'h0000_0000);
    n = msg_cnt;
    pulse(1'b1);
    repeat (6) @(posedge clk);
    check("msi count", msg_cnt, n);
    // Return to D0 without kept context wipes the interrupt setup
    cfg_wr(pmc_pkg::PMC_OFF_CAP, 32'h0001_0000);
    cfg_unlock <= 1'b1;
    cfg_wr(pmc_pkg::PMC_OFF_PM, 32'h0000_0103);
    cfg_unlock <= 1'b0;
    cfg_wr(pmc_pkg::PMC_OFF_PM, 32'h0000_0100);
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_8100);
    rd_chk(pmc_pkg::PMC_OFF_CAP, 32'h0080_FF05);
    rd_chk(pmc_pkg::PMC_OFF_DAT, 32'h0000_0000);
    // Upstream port: own events never reach the status bit
    do_reset(1'b1);
    cfg_wr(pmc_pkg::PMC_OFF_PM, 32'h0000_0100);
    pulse(1'b0);
    check("pm_event_msg", pm_event_msg, 1'b0);
    rd_chk(pmc_pkg::PMC_OFF_PM, 32'h0000_0108);
    stop_test();
  end
endmodule // pmc_port_cfg_tb

`default_nettype wire
